// ---- hw/dfu_pkg.sv ----
// constants, types and register map of the divide/extend/far-move unit
// assumes a single clock domain and an AHB-Lite master with word transfers
package dfu_pkg;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] ADDR_SRC = 8'h00;
    localparam logic [7:0] ADDR_DST = 8'h04;
    localparam logic [7:0] ADDR_UPPER = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_FAR = 8'h18;
    localparam logic [7:0] ADDR_NEAR = 8'h1C;
    localparam logic [7:0] ADDR_MEMDATA = 8'h20;
    // ==========================================
    // field positions
    localparam int CTRL_UPPER_BIT = 4;
    localparam int CTRL_DIR_BIT = 5;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_DONE_BIT = 1;
    // ==========================================
    // operation codes in ctrl[3:0]
    localparam logic [3:0] OP_UWD = 4'h0;
    localparam logic [3:0] OP_ULD = 4'h1;
    localparam logic [3:0] OP_SWD = 4'h2;
    localparam logic [3:0] OP_SLD = 4'h3;
    localparam logic [3:0] OP_BZE = 4'h4;
    localparam logic [3:0] OP_WZE = 4'h5;
    localparam logic [3:0] OP_BSE = 4'h6;
    localparam logic [3:0] OP_WSE = 4'h7;
    localparam logic [3:0] OP_FMV = 4'h8;
    // ==========================================
    // cycle counts
    localparam logic [4:0] CYC_SWD = 5'd27;
    localparam logic [4:0] CYC_SWD_ZERO = 5'd4;
    localparam logic [4:0] CYC_SWD_MIN = 5'd26;
    localparam logic [4:0] CYC_SLD = 5'd29;
    localparam logic [4:0] CYC_SLD_MIN_POS = 5'd6;
    localparam logic [4:0] CYC_SLD_MIN_NEG = 5'd7;
    localparam logic [4:0] CYC_SLD_BIG_POS = 5'd8;
    localparam logic [4:0] CYC_SLD_BIG_NEG = 5'd9;
    localparam logic [4:0] CYC_SLD_OVF = 5'd28;
    localparam logic [4:0] CYC_UWD = 5'd21;
    localparam logic [4:0] CYC_UWD_ZERO = 5'd5;
    localparam logic [4:0] CYC_ULD = 5'd21;
    localparam logic [4:0] CYC_ULD_OVF = 5'd4;
    localparam logic [4:0] CYC_EXT = 5'd1;
    localparam logic [4:0] CYC_FMV = 5'd4;
    // ==========================================
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [16:0] RST_ADDR = 17'h0_0000;
    // ==========================================
    // types
    typedef struct packed {
        logic z;
        logic n;
        logic c;
        logic v;
    } flag_word_s;
    typedef enum logic {st_idle, st_run} state_e;
endpackage

// ---- hw/divide_extend_farmove_unit.sv ----
// divide, sign/zero extend and far-move datapath behind an AHB-Lite slave
// assumes one clock, synchronous inputs, single word transfers only
//
// Function
// - quotient to destination, remainder to upper word
// - long dividend is upper word then destination
// - remainder first; quotient overwrites it in upper
// - signed remainder takes the dividend's sign
// - signed overflow: zero, 8000h/FFFFh, oversize quotient
// - overflow leaves source, upper, destination unchanged
// - signed flags: zero per divisor/quotient, carry cleared
// - negative is prior overflow xor quotient sign
// - signed word divide takes 27, 4, 26 cycles
// - signed long divide 29, early overflow exits
// - unsigned: carry on overflow, flags follow divisor
// - unsigned word divide 21 cycles, zero 5
// - unsigned long divide 21, overflow 4 cycles
// - byte zero extend clears upper byte only
// - word zero extend clears only upper word
// - far address is pointer shifted, bit zero low
// - direct operand addresses lower 64K bytes directly
// - far move sets zero, negative; clears overflow
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module divide_extend_farmove_unit
    import dfu_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic busy
);
    // ==========================================
    // state
    state_e state_reg;
    logic [4:0] cnt_reg;
    logic [4:0] elapsed_reg;
    logic [3:0] op_reg;
    logic to_upper_reg;
    logic dir_reg;
    logic done_reg;
    logic [15:0] src_reg;
    logic [15:0] dst_reg;
    logic [15:0] upper_reg;
    logic [15:0] mem_data_reg;
    flag_word_s flags_reg;
    logic [16:0] far_addr_reg;
    logic [16:0] near_addr_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;

    // ==========================================
    // bus decode
    wire idle = state_reg == st_idle;
    wire addr_ok = hsel && htrans[1] && hready;
    wire wr_req = addr_ok && hwrite;
    wire rd_req = addr_ok && !hwrite;
    wire wr_src = wr_pend_reg && wr_addr_reg == ADDR_SRC && idle;
    wire wr_dst = wr_pend_reg && wr_addr_reg == ADDR_DST && idle;
    wire wr_upper = wr_pend_reg && wr_addr_reg == ADDR_UPPER && idle;
    wire wr_flags = wr_pend_reg && wr_addr_reg == ADDR_FLAGS && idle;
    wire wr_mem = wr_pend_reg && wr_addr_reg == ADDR_MEMDATA && idle;
    wire start = wr_pend_reg && wr_addr_reg == ADDR_CTRL && idle && hwdata[3:0] <= OP_FMV;
    wire commit = !idle && cnt_reg == CYC_EXT;
    wire [31:0] rd_data =
        haddr[7:0] == ADDR_SRC ? {16'h0000, src_reg} :
        haddr[7:0] == ADDR_DST ? {16'h0000, dst_reg} :
        haddr[7:0] == ADDR_UPPER ? {16'h0000, upper_reg} :
        haddr[7:0] == ADDR_FLAGS ? {28'h000_0000, flags_reg} :
        haddr[7:0] == ADDR_CTRL ? {26'h000_0000, dir_reg, to_upper_reg, op_reg} :
        haddr[7:0] == ADDR_STATUS ? {30'h0000_0000, done_reg, !idle} :
        haddr[7:0] == ADDR_FAR ? {15'h0000, far_addr_reg} :
        haddr[7:0] == ADDR_NEAR ? {15'h0000, near_addr_reg} :
        haddr[7:0] == ADDR_MEMDATA ? {16'h0000, mem_data_reg} : 32'h0000_0000;

    // ==========================================
    // operand selection
    wire [3:0] cur_op = idle ? hwdata[3:0] : op_reg;
    wire cur_up = (idle ? hwdata[CTRL_UPPER_BIT] : to_upper_reg) && cur_op != OP_WZE;
    wire cur_dir = idle ? hwdata[CTRL_DIR_BIT] : dir_reg;
    wire is_div = cur_op <= OP_SLD;
    wire is_fmv = cur_op == OP_FMV;
    wire is_long = cur_op == OP_ULD || cur_op == OP_SLD;
    wire is_signed = cur_op == OP_SWD || cur_op == OP_SLD;
    wire [15:0] dst_val = cur_up ? upper_reg : dst_reg;

    // ==========================================
    // division
    wire [31:0] dvd = is_long ? {upper_reg, dst_val} :
        {is_signed && dst_val[15] ? 16'hFFFF : 16'h0000, dst_val};
    wire dvd_neg = is_signed && dvd[31];
    wire dvs_neg = is_signed && src_reg[15];
    wire q_neg = dvd_neg ^ dvs_neg;
    wire [31:0] dvd_mag = dvd_neg ? ~dvd + 32'h0000_0001 : dvd;
    wire [15:0] dvs_mag = dvs_neg ? ~src_reg + 16'h0001 : src_reg;
    wire dvs_zero = src_reg == 16'h0000;
    wire [31:0] dvs_safe = {16'h0000, dvs_zero ? 16'h0001 : dvs_mag};
    wire [31:0] q_mag = dvd_mag / dvs_safe;
    wire [31:0] r_mag = dvd_mag % dvs_safe;
    wire [15:0] q16 = q_neg ? ~q_mag[15:0] + 16'h0001 : q_mag[15:0];
    wire [15:0] r16 = dvd_neg ? ~r_mag[15:0] + 16'h0001 : r_mag[15:0];
    wire sgn_ovf = dvs_zero || (q_neg ? q_mag > 32'h0000_8000 : q_mag > 32'h0000_7FFF);
    wire uns_ovf = dvs_zero || q_mag > 32'h0000_FFFF;
    wire div_ovf = is_signed ? sgn_ovf : uns_ovf;
    wire dvd_big = dvd_mag >= {dvs_mag, 16'h0000};

    // ==========================================
    // cycle counts
    wire [4:0] swd_cnt = dvs_zero ? CYC_SWD_ZERO : sgn_ovf ? CYC_SWD_MIN : CYC_SWD;
    wire [4:0] sld_cnt =
        dvd == 32'h8000_0000 ? (src_reg[15] ? CYC_SLD_MIN_NEG : CYC_SLD_MIN_POS) :
        dvs_zero || dvd_big ? (src_reg[15] ? CYC_SLD_BIG_NEG : CYC_SLD_BIG_POS) :
        sgn_ovf ? CYC_SLD_OVF : CYC_SLD;
    wire [4:0] uwd_cnt = dvs_zero ? CYC_UWD_ZERO : CYC_UWD;
    wire [4:0] uld_cnt = uns_ovf ? CYC_ULD_OVF : CYC_ULD;
    wire [4:0] cnt_load =
        cur_op == OP_UWD ? uwd_cnt :
        cur_op == OP_ULD ? uld_cnt :
        cur_op == OP_SWD ? swd_cnt :
        cur_op == OP_SLD ? sld_cnt :
        is_fmv ? CYC_FMV : CYC_EXT;

    // ==========================================
    // extension and far move
    wire [15:0] dst_ext =
        cur_op == OP_BZE ? {8'h00, dst_val[7:0]} :
        cur_op == OP_BSE ? {dst_val[7] ? 8'hFF : 8'h00, dst_val[7:0]} : dst_val;
    wire [15:0] upper_ext =
        cur_op == OP_WZE ? 16'h0000 :
        cur_op == OP_WSE ? (dst_val[15] ? 16'hFFFF : 16'h0000) : upper_reg;
    wire ext_n = cur_op == OP_BZE ? dst_val[7] : cur_op == OP_WZE ? 1'b0 :
        cur_op == OP_WSE ? dst_val[15] : dst_ext[15];
    wire [15:0] ind_ptr = cur_dir ? src_reg : dst_reg;
    wire [15:0] direct_ptr = cur_dir ? dst_reg : src_reg;

    // ==========================================
    // results and flags
    wire [15:0] res_dst = is_div ? (div_ovf ? dst_val : q16) : is_fmv ? dst_val : dst_ext;
    wire [15:0] res_upper = is_div ? (div_ovf ? upper_reg : r16) : upper_ext;
    wire [3:0] sflags = {sgn_ovf ? dvs_zero : q16 == 16'h0000, flags_reg.v ^ q_neg,
        1'b0, sgn_ovf};
    wire [3:0] uflags = {uns_ovf ? dvs_zero : q16 == 16'h0000,
        uns_ovf ? src_reg[15] : q16[15], uns_ovf, 1'b0};
    wire [3:0] fflags = {mem_data_reg == 16'h0000, mem_data_reg[15], flags_reg.c, 1'b0};
    wire [3:0] eflags = {dst_ext == 16'h0000, ext_n, flags_reg.c, 1'b0};
    wire flag_word_s flags_next = is_div ? (is_signed ? sflags : uflags) :
        is_fmv ? fflags : eflags;

    // ==========================================
    // bus slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else if (ce) begin
            wr_pend_reg <= wr_req;
            wr_addr_reg <= haddr[7:0];
            hreadyout <= 1'b1;
            if (rd_req) begin
                hrdata <= rd_data;
            end
        end
    end

    // ==========================================
    // sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= st_idle;
            cnt_reg <= 5'd0;
            elapsed_reg <= 5'd0;
            op_reg <= OP_UWD;
            to_upper_reg <= 1'b0;
            dir_reg <= 1'b0;
            done_reg <= 1'b0;
            busy <= 1'b0;
        end else if (ce) begin
            if (start) begin
                state_reg <= st_run;
                cnt_reg <= cnt_load;
                elapsed_reg <= 5'd1;
                op_reg <= hwdata[3:0];
                to_upper_reg <= hwdata[CTRL_UPPER_BIT];
                dir_reg <= hwdata[CTRL_DIR_BIT];
                done_reg <= 1'b0;
                busy <= 1'b1;
            end else if (commit) begin
                state_reg <= st_idle;
                done_reg <= 1'b1;
                busy <= 1'b0;
            end else if (!idle) begin
                cnt_reg <= cnt_reg - 5'd1;
                elapsed_reg <= elapsed_reg + 5'd1;
            end
        end
    end

    // ==========================================
    // register file
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_reg <= RST_WORD;
            dst_reg <= RST_WORD;
            upper_reg <= RST_WORD;
            mem_data_reg <= RST_WORD;
            flags_reg <= 4'h0;
            far_addr_reg <= RST_ADDR;
            near_addr_reg <= RST_ADDR;
        end else if (ce) begin
            if (wr_src) src_reg <= hwdata[15:0];
            if (wr_dst) dst_reg <= hwdata[15:0];
            if (wr_upper) upper_reg <= hwdata[15:0];
            if (wr_mem) mem_data_reg <= hwdata[15:0];
            if (wr_flags) flags_reg <= hwdata[3:0];
            if (commit) begin
                // remainder lands first, quotient wins when upper is the target
                upper_reg <= cur_up ? res_dst : res_upper;
                dst_reg <= cur_up ? dst_reg : res_dst;
                flags_reg <= flags_next;
                if (is_fmv) begin
                    far_addr_reg <= {ind_ptr, 1'b0};
                    near_addr_reg <= {1'b0, direct_ptr};
                end
            end
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_ovf_keeps_regs: assert property (
        ce && commit && is_div && div_ovf |=> $stable(dst_reg) && $stable(upper_reg)
            && $stable(src_reg))
        else $error("overflow changed a register");
    a_swd_cycles: assert property (
        commit && op_reg == OP_SWD |-> elapsed_reg == (dvs_zero ? 5'd4 : sgn_ovf ? 5'd26 : 5'd27))
        else $error("signed word divide length wrong");
    a_sld_cycles: assert property (
        commit && op_reg == OP_SLD && !div_ovf |-> elapsed_reg == 5'd29)
        else $error("signed long divide length wrong");
    a_uwd_cycles: assert property (
        commit && op_reg == OP_UWD |-> elapsed_reg == (dvs_zero ? 5'd5 : 5'd21))
        else $error("unsigned word divide length wrong");
    a_uld_cycles: assert property (
        commit && op_reg == OP_ULD |-> elapsed_reg == (uns_ovf ? 5'd4 : 5'd21))
        else $error("unsigned long divide length wrong");
    a_rem_sign: assert property (
        ce && commit && is_signed && !div_ovf && !to_upper_reg |=>
            upper_reg == 16'h0000 || upper_reg[15] == $past(dvd[31]))
        else $error("remainder sign differs from dividend");
    a_quot_over_rem: assert property (
        ce && commit && is_div && !div_ovf && to_upper_reg |=> upper_reg == $past(q16))
        else $error("quotient did not overwrite remainder");
    a_uns_flags: assert property (
        ce && commit && is_div && !is_signed && div_ovf |=>
            flags_reg.c && !flags_reg.v && flags_reg.z == $past(dvs_zero))
        else $error("unsigned overflow flags wrong");
    a_bze_upper_clear: assert property (
        ce && commit && op_reg == OP_BZE && !to_upper_reg |=>
            dst_reg[15:8] == 8'h00 && dst_reg[7:0] == $past(dst_reg[7:0]))
        else $error("byte zero extend wrong");
    a_far_address: assert property (
        ce && commit && is_fmv |=> far_addr_reg == {$past(ind_ptr), 1'b0})
        else $error("far address wrong");
    a_far_flags: assert property (
        ce && commit && is_fmv |=> !flags_reg.v && flags_reg.c == $past(flags_reg.c))
        else $error("far move flags wrong");

    // ==========================================
    // flag, datapath and sequencing checks
    a_busy_freeze: assert property (
        ce && !idle && !commit |=> $stable(dst_reg) && $stable(upper_reg)
            && $stable(src_reg) && $stable(flags_reg))
        else $error("register moved mid operation");

    a_done_flag: assert property (
        ce && commit |=> done_reg && !busy && idle)
        else $error("commit did not finish");

    a_uns_result: assert property (
        ce && commit && is_div && !is_signed && !div_ovf && !to_upper_reg |=>
            {16'h0000, dst_reg} * {16'h0000, src_reg} + {16'h0000, upper_reg} == $past(dvd)
            && upper_reg < src_reg)
        else $error("unsigned quotient or remainder wrong");

    a_uns_flags_ok: assert property (
        ce && commit && is_div && !is_signed && !div_ovf |=> !flags_reg.c && !flags_reg.v
            && flags_reg.n == (to_upper_reg ? upper_reg[15] : dst_reg[15]))
        else $error("unsigned flags wrong");

    a_sgn_flags: assert property (
        ce && commit && is_div && is_signed && !div_ovf |=> !flags_reg.c && !flags_reg.v
            && flags_reg.z == ((to_upper_reg ? upper_reg : dst_reg) == 16'h0000))
        else $error("signed flags wrong");

    a_sgn_zero_div: assert property (
        ce && commit && is_div && is_signed && dvs_zero |=> flags_reg.v && flags_reg.z
            && !flags_reg.c)
        else $error("signed zero divisor flags wrong");

    a_sgn_neg: assert property (
        ce && commit && is_div && is_signed |=>
            flags_reg.n == ($past(flags_reg.v) ^ $past(src_reg[15]) ^ $past(dvd[31])))
        else $error("signed negative flag wrong");

    a_sld_zero_cycles: assert property (
        commit && op_reg == OP_SLD && dvs_zero && dvd != 32'h8000_0000 |->
            elapsed_reg == CYC_SLD_BIG_POS)
        else $error("signed long zero divisor length wrong");

    a_wze_upper: assert property (
        ce && commit && op_reg == OP_WZE |=> upper_reg == 16'h0000 && $stable(dst_reg))
        else $error("word zero extend wrong");

    a_near_address: assert property (
        ce && commit && is_fmv |=>
            near_addr_reg == {1'b0, (dir_reg ? dst_reg : src_reg)})
        else $error("near address wrong");

    a_far_zero: assert property (
        ce && commit && is_fmv |=> flags_reg.z == (mem_data_reg == 16'h0000)
            && flags_reg.n == mem_data_reg[15])
        else $error("far move zero or negative flag wrong");

    c_sld_overflow: cover property (commit && op_reg == OP_SLD && div_ovf);
    c_uwd_normal: cover property (commit && op_reg == OP_UWD && !div_ovf);
    c_far_move: cover property (commit && op_reg == OP_FMV);
    c_quot_to_upper: cover property (commit && is_div && to_upper_reg && !div_ovf);
endmodule

// ---- bench/ahb_seq_model.sv ----
// AHB-Lite master standing in for the cpu sequencer and register file
// assumes one slave whose hreadyout is looped back as hready
`timescale 1ns/1ps
module ahb_seq_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
    end

    // ==========================================
    // single word transfer, entered just after an edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
        // select stays up; idle htrans means no request
        // released data lines do not keep the last value
        hwdata <= ~d;
    endtask
endmodule

// ---- bench/tb_divide_extend_farmove_unit.sv ----
// self-checking bench of the divide/extend/far-move unit
// assumes the package register map and a 20 MHz clock
`timescale 1ns/1ps
module tb_divide_extend_farmove_unit;
    import dfu_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel, hwrite, hreadyout, hresp, busy;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] seed = 32'h0001_361C;
    logic [15:0] e_dst, e_up;
    logic [3:0] e_flg;
    int e_cyc;
    int busy_cnt = 0;
    int fail_count = 0;
    int tests_run = 0;

    always #25 hclk = ~hclk;
    always @(posedge hclk) if (busy === 1'b1) busy_cnt++;

    divide_extend_farmove_unit divide_extend_farmove_unit_inst (.hclk(hclk),
        .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy));
    ahb_seq_model ahb_seq_model_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_cyc(input int exp, input int got);
        tests_run++;
        if (got != exp) begin
            fail_count++;
            $display("BAD cycles expected %0d seen %0d", exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb_seq_model_inst.xfer(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        ahb_seq_model_inst.xfer(a, 1'b0, 32'h0000_0000, q);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================
    // reference model
    task automatic model(input logic [3:0] op, input logic ud, input logic [15:0] s, d, u,
                         input logic [3:0] f, input logic [15:0] m);
        longint dv, sv, q, r, av, as;
        logic [15:0] lo;
        logic ovf;
        lo = ud ? u : d;
        e_dst = d;
        e_up = u;
        ovf = 1'b0;
        e_cyc = 1;
        e_flg = {d == 16'h0000, 1'b0, f[1], 1'b0};
        if (op == OP_UWD || op == OP_ULD) begin
            dv = (op == OP_ULD) ? {32'h0000_0000, u, lo} : {48'h0000_0000_0000, lo};
            ovf = (s == 16'h0000) || (dv >= {32'h0000_0000, s, 16'h0000});
            e_cyc = ovf ? ((op == OP_UWD) ? 5 : 4) : 21;
            q = ovf ? 0 : dv / s;
            r = ovf ? 0 : dv % s;
            e_flg = {ovf ? s == 16'h0000 : q[15:0] == 16'h0000, ovf ? s[15] : q[15], ovf, 1'b0};
        end else if (op == OP_SWD || op == OP_SLD) begin
            dv = (op == OP_SLD) ? longint'($signed({u, lo})) : longint'($signed(lo));
            sv = longint'($signed(s));
            q = (sv != 0) ? dv / sv : 0;
            r = (sv != 0) ? dv % sv : 0;
            av = (dv < 0) ? -dv : dv;
            as = (sv < 0) ? -sv : sv;
            ovf = (sv == 0) || (q > 32767) || (q < -32768);
            if (op == OP_SWD) e_cyc = (sv == 0) ? 4 : (ovf ? 26 : 27);
            else if (u == 16'h8000 && lo == 16'h0000) e_cyc = s[15] ? 7 : 6;
            else if (sv == 0 || av >= (as << 16)) e_cyc = s[15] ? 9 : 8;
            else e_cyc = ovf ? 28 : 29;
            e_flg = {ovf ? s == 16'h0000 : q[15:0] == 16'h0000,
                     f[0] ^ s[15] ^ ((op == OP_SLD) ? u[15] : lo[15]), 1'b0, ovf};
        end else if (op == OP_BZE) begin
            e_dst = {8'h00, d[7:0]};
            e_flg = {e_dst == 16'h0000, d[7], f[1], 1'b0};
        end else if (op == OP_BSE) begin
            e_dst = {{8{d[7]}}, d[7:0]};
            e_flg = {e_dst == 16'h0000, d[7], f[1], 1'b0};
        end else if (op == OP_WZE) begin
            e_up = 16'h0000;
        end else if (op == OP_WSE) begin
            e_up = {16{d[15]}};
            e_flg[2] = d[15];
        end else begin
            e_cyc = 4;
            e_flg = {m == 16'h0000, m[15], f[1], 1'b0};
        end
        if (op <= OP_SLD && !ovf) begin
            e_up = ud ? q[15:0] : r[15:0];
            if (!ud) e_dst = q[15:0];
        end
    endtask

    // ==========================================
    // one operation: load, start, poll, compare
    task automatic run(input logic [3:0] op, input logic [1:0] b, input logic [15:0] s, d, u,
                       input logic [3:0] f, input logic [15:0] m, input int mode);
        logic [31:0] q;
        int i;
        model(op, b[0], s, d, u, f, m);
        wr(ADDR_SRC, {16'h0000, s});
        wr(ADDR_DST, {16'h0000, d});
        wr(ADDR_UPPER, {16'h0000, u});
        wr(ADDR_FLAGS, {28'h000_0000, f});
        wr(ADDR_MEMDATA, {16'h0000, m});
        busy_cnt = 0;
        wr(ADDR_CTRL, {24'h00_0000, 2'b00, b, op});
        if (mode == 1) wr(ADDR_SRC, 32'h0000_5A5A);
        if (mode == 2) begin
            ce <= 1'b0;
            repeat (3) @(posedge hclk);
            ce <= 1'b1;
            e_cyc += 3;
        end
        i = 0;
        do begin
            rd(ADDR_STATUS, q);
            i++;
        end while (q[0] !== 1'b0 && i < 40);
        chk_cyc(e_cyc, busy_cnt);
        chk_val("status", 32'h0000_0002, q);
        rd(ADDR_DST, q);
        chk_val("destination", {16'h0000, e_dst}, q);
        rd(ADDR_UPPER, q);
        chk_val("upper", {16'h0000, e_up}, q);
        rd(ADDR_SRC, q);
        chk_val("source", {16'h0000, s}, q);
        rd(ADDR_FLAGS, q);
        chk_val("flags", {28'h000_0000, e_flg}, q);
        chk_val("response", 32'h0000_0000, {31'h0000_0000, hresp});
    endtask

    initial begin
        #1000000;
        fail_count++;
        end_of_test();
    end

    initial begin
        logic [31:0] q, r;
        logic [3:0] ops[4] = '{OP_UWD, OP_ULD, OP_SWD, OP_SLD};
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        for (int a = 0; a <= 36; a += 4) begin
            rd(8'(a), q);
            chk_val("reset value", 32'h0000_0000, q);
        end
        wr(8'h24, 32'hFFFF_FFFF);
        rd(8'h24, q);
        chk_val("unmapped", 32'h0000_0000, q);
        wr(ADDR_FAR, 32'h0001_FFFE);
        rd(ADDR_FAR, q);
        chk_val("far read only", 32'h0000_0000, q);
        run(OP_UWD, 2'b00, 16'h0000, 16'h1234, 16'h7777, 4'h4, 16'h0000, 0);
        run(OP_ULD, 2'b00, 16'h0010, 16'h0000, 16'h0010, 4'h0, 16'h0000, 0);
        run(OP_ULD, 2'b01, 16'h0100, 16'h3000, 16'h0020, 4'h0, 16'h0000, 0);
        run(OP_SWD, 2'b00, 16'h0000, 16'h1234, 16'h0001, 4'h1, 16'h0000, 0);
        run(OP_SWD, 2'b00, 16'hFFFF, 16'h8000, 16'h0001, 4'h0, 16'h0000, 0);
        run(OP_SWD, 2'b00, 16'h0007, 16'hFFF0, 16'h0000, 4'h1, 16'h0000, 0);
        run(OP_SLD, 2'b00, 16'h0003, 16'h0000, 16'h8000, 4'h0, 16'h0000, 0);
        run(OP_SLD, 2'b00, 16'hFFFD, 16'h0000, 16'h8000, 4'h0, 16'h0000, 0);
        run(OP_SLD, 2'b00, 16'h0002, 16'h0000, 16'h0002, 4'h0, 16'h0000, 0);
        run(OP_SLD, 2'b00, 16'hFFFE, 16'h0000, 16'h0002, 4'h0, 16'h0000, 0);
        run(OP_SLD, 2'b00, 16'h0002, 16'h0000, 16'h0001, 4'h0, 16'h0000, 0);
        run(OP_SLD, 2'b00, 16'h0002, 16'h0003, 16'hFFFF, 4'h0, 16'h0000, 0);
        run(OP_SLD, 2'b00, 16'h0000, 16'h0005, 16'h0000, 4'h0, 16'h0000, 0);
        run(OP_UWD, 2'b00, 16'h0003, 16'h0064, 16'h0000, 4'h0, 16'h0000, 1);
        run(OP_SWD, 2'b00, 16'hFFF9, 16'h0064, 16'h0000, 4'h0, 16'h0000, 2);
        for (int i = 0; i < 16; i++) begin
            r = lfsr();
            q = lfsr();
            run(ops[i % 4], {1'b0, r[9]}, r[15:0], q[15:0],
                i[2] ? q[31:16] : {12'h000, r[19:16]}, r[23:20], 16'h0000, 0);
        end
        for (int i = 4; i < 8; i++) begin
            r = lfsr();
            run(4'(i), 2'b00, r[15:0], r[31:16], 16'h5555, 4'hF, 16'h0000, 0);
        end
        for (int i = 0; i < 2; i++) begin
            r = lfsr();
            run(OP_FMV, {i[0], 1'b0}, r[15:0], r[31:16], 16'h0000, 4'hF,
                i[0] ? 16'h0000 : {1'b1, r[22:8]}, 0);
            rd(ADDR_FAR, q);
            chk_val("far address", {15'h0000, i[0] ? r[15:0] : r[31:16], 1'b0}, q);
            rd(ADDR_NEAR, q);
            chk_val("near address", {16'h0000, i[0] ? r[31:16] : r[15:0]}, q);
        end
        wr(ADDR_CTRL, 32'h0000_0009);
        rd(ADDR_STATUS, q);
        chk_val("bad op idle", 32'h0000_0000, {31'h0000_0000, q[0]});
        end_of_test();
    end
endmodule
